// ===== rtl/uec_cfg.svh
// constants for the endpoint-zero control transfer handler
`ifndef UEC_CFG_SVH
`define UEC_CFG_SVH

// register byte offsets inside region 0
`define UEC_OFS_OUT_CFG 8'h00
`define UEC_OFS_OUT_CNT 8'h04
`define UEC_OFS_IN_CFG 8'h08
`define UEC_OFS_IN_CNT 8'h0c
`define UEC_OFS_STATUS 8'h10

// address regions, paddr[9:8]
`define UEC_REG_REGS 2'h0
`define UEC_REG_OUT_BUF 2'h1
`define UEC_REG_IN_BUF 2'h2
`define UEC_REG_SETUP_BUF 2'h3

// endpoint configuration fields
`define UEC_CFG_STALL 0
`define UEC_CFG_TOGGLE 1
`define UEC_CFG_HOLD 2
`define UEC_CFG_ENABLE 3
`define UEC_CFG_IRQ_EN 4

// status fields
`define UEC_ST_SETUP 0
`define UEC_ST_SETUP_IRQ 1
`define UEC_ST_OUT_IRQ 2
`define UEC_ST_IN_IRQ 3

// reset values
`define UEC_CFG_RST 5'h04
`define UEC_CNT_RST 7'h00

// buffer sizes
`define UEC_EP0_BYTES 64
`define UEC_SETUP_BYTES 8

`endif

// ===== rtl/uec_pkg.sv
// types shared by the endpoint-zero control transfer handler
package uec_pkg;

   typedef enum logic [1:0] {UEC_PID_OUT, UEC_PID_IN, UEC_PID_SETUP} uec_pid_t;

   typedef enum logic [1:0] {UEC_HS_ACK, UEC_HS_NAK, UEC_HS_STALL} uec_hs_t;

   typedef struct packed {
      logic valid;
      uec_pid_t pid;
      logic [3:0] ep;
   } uec_tok_t;

   typedef struct packed {
      logic byte_valid;
      logic [7:0] data;
      logic done;
      logic err;
      logic data1;
   } uec_rx_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
      logic last;
      logic empty;
      logic data1;
   } uec_tx_t;

   typedef struct packed {
      logic irq_en;
      logic enable;
      logic hold;
      logic toggle;
      logic stall;
   } uec_ep_cfg_t;

endpackage

// ===== rtl/uec_buf_mem.sv
// simple dual-port byte buffer with registered read data
`timescale 1ns/1ps
module uec_buf_mem #(
   parameter int DW = 8,
   parameter int DEPTH = 64,
   parameter int AW = $clog2(DEPTH)
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_n_i,
   // write port
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   // read port
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);

   logic [DW-1:0] mem [DEPTH];
   logic [DW-1:0] rdata_q;

   always_ff @(posedge clk_i)
   begin
      if (we_i)
      begin
         mem[waddr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         rdata_q <= '0;
      end
      else
      begin
         rdata_q <= mem[raddr_i];
      end
   end

   assign rdata_o = rdata_q;

endmodule

// ===== rtl/uec_ep0.sv
// endpoint-zero control transfer handler of the usb buffer manager
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "uec_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module uec_ep0
   import uec_pkg::*;
#(
   parameter int BUF_BYTES = `UEC_EP0_BYTES,
   parameter int SETUP_BYTES = `UEC_SETUP_BYTES
) (
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RESET_N_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   output logic PREADY_O,
   output logic [31:0] PRDATA_O,
   output logic PSLVERR_O,
   // serial interface engine side
   input wire uec_tok_t SIE_TOK_I,
   input wire uec_rx_t SIE_RX_I,
   input wire logic SIE_HS_ACK_I,
   input wire logic SIE_HS_TIMEOUT_I,
   output uec_tx_t SIE_TX_O,
   input wire logic SIE_TX_READY_I,
   output logic HS_VALID_O,
   output uec_hs_t HS_CODE_O,
   // interrupt requests to the microcontroller
   output logic SETUP_IRQ_O,
   output logic OUT_IRQ_O,
   output logic IN_IRQ_O
);

   localparam int AW = $clog2(BUF_BYTES);
   localparam int SAW = $clog2(SETUP_BYTES);
   localparam int CW = AW + 1;

   typedef enum logic [2:0] {S_IDLE, S_RX_SETUP, S_RX_OUT, S_TX_FETCH, S_TX_SEND,
                             S_WAIT_HS} uec_state_t;

   uec_state_t state_q;
   uec_ep_cfg_t out_cfg_q, in_cfg_q;
   logic [CW-1:0] out_cnt_q, in_cnt_q, idx_q;
   logic setup_flag_q, setup_irq_q, out_irq_q, in_irq_q;
   logic accept_q, stall_q, setup_bad_q;
   logic hs_valid_q;
   uec_hs_t hs_code_q;
   logic [31:0] prdata_q;
   logic [1:0] rd_region_q;
   logic err_q;

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode

   logic apb_setup, apb_wr, wr_out_cfg, wr_in_cfg, wr_in_cnt, wr_status, wr_in_buf;
   logic [1:0] region;
   logic [7:0] offset;
   logic unmapped;

   assign region = PADDR_I[9:8];
   assign offset = PADDR_I[7:0];
   assign apb_setup = PSEL_I && !PENABLE_I;
   assign apb_wr = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && !err_q;
   assign wr_out_cfg = apb_wr && region == `UEC_REG_REGS && offset == `UEC_OFS_OUT_CFG;
   assign wr_in_cfg = apb_wr && region == `UEC_REG_REGS && offset == `UEC_OFS_IN_CFG;
   assign wr_in_cnt = apb_wr && region == `UEC_REG_REGS && offset == `UEC_OFS_IN_CNT;
   assign wr_status = apb_wr && region == `UEC_REG_REGS && offset == `UEC_OFS_STATUS;
   assign wr_in_buf = apb_wr && region == `UEC_REG_IN_BUF;

   always_comb
   begin
      unmapped = 1'b0;
      unique case (region)
         `UEC_REG_REGS: unmapped = offset > `UEC_OFS_STATUS || offset[1:0] != 2'h0;
         `UEC_REG_SETUP_BUF: unmapped = (PADDR_I[7:2] >> SAW) != '0;
         default: unmapped = (PADDR_I[7:2] >> AW) != '0;
      endcase
      if (PADDR_I[11:10] != 2'h0)
      begin
         unmapped = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // buffers

   logic [7:0] out_rdata, in_rdata, setup_rdata;
   logic out_we, setup_we;

   assign out_we = state_q == S_RX_OUT && accept_q && SIE_RX_I.byte_valid
                   && idx_q < CW'(BUF_BYTES);
   assign setup_we = state_q == S_RX_SETUP && SIE_RX_I.byte_valid
                     && idx_q < CW'(SETUP_BYTES);

   uec_buf_mem #(.DW(8), .DEPTH(BUF_BYTES)) u_out_buf (
      .clk_i(CLK_SYS_I),
      .reset_n_i(RESET_N_I),
      .we_i(out_we),
      .waddr_i(idx_q[AW-1:0]),
      .wdata_i(SIE_RX_I.data),
      .raddr_i(PADDR_I[AW+1:2]),
      .rdata_o(out_rdata)
   );

   uec_buf_mem #(.DW(8), .DEPTH(BUF_BYTES)) u_in_buf (
      .clk_i(CLK_SYS_I),
      .reset_n_i(RESET_N_I),
      .we_i(wr_in_buf),
      .waddr_i(PADDR_I[AW+1:2]),
      .wdata_i(PWDATA_I[7:0]),
      .raddr_i(idx_q[AW-1:0]),
      .rdata_o(in_rdata)
   );

   uec_buf_mem #(.DW(8), .DEPTH(SETUP_BYTES)) u_setup_buf (
      .clk_i(CLK_SYS_I),
      .reset_n_i(RESET_N_I),
      .we_i(setup_we),
      .waddr_i(idx_q[SAW-1:0]),
      .wdata_i(SIE_RX_I.data),
      .raddr_i(PADDR_I[SAW+1:2]),
      .rdata_o(setup_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // transaction sequencer

   logic tok_ep0, rx_good, rx_bad;
   logic out_done, in_acked;

   assign tok_ep0 = SIE_TOK_I.valid && SIE_TOK_I.ep == 4'h0;
   assign rx_good = SIE_RX_I.done && !SIE_RX_I.err;
   assign rx_bad = SIE_RX_I.done && SIE_RX_I.err;
   // out count, toggle and hold updated only when the data pid matches the expected toggle
   assign out_done = state_q == S_RX_OUT && rx_good && accept_q
                     && SIE_RX_I.data1 == out_cfg_q.toggle;
   assign in_acked = state_q == S_WAIT_HS && SIE_HS_ACK_I;

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         state_q <= S_IDLE;
         idx_q <= '0;
         accept_q <= 1'b0;
         stall_q <= 1'b0;
         setup_bad_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            S_IDLE:
            begin
               idx_q <= '0;
               if (tok_ep0)
               begin
                  // setup flag overrides hold and stall
                  setup_bad_q <= setup_flag_q;
                  unique case (SIE_TOK_I.pid)
                     UEC_PID_SETUP: state_q <= S_RX_SETUP;
                     UEC_PID_OUT:
                     begin
                        stall_q <= out_cfg_q.stall;
                        accept_q <= !setup_flag_q && !out_cfg_q.stall && !out_cfg_q.hold
                                    && out_cfg_q.enable;
                        state_q <= S_RX_OUT;
                     end
                     UEC_PID_IN:
                     begin
                        if (!setup_flag_q && !in_cfg_q.stall && !in_cfg_q.hold
                            && in_cfg_q.enable)
                        begin
                           state_q <= S_TX_FETCH;
                        end
                     end
                     default: state_q <= S_IDLE;
                  endcase
               end
            end
            S_RX_SETUP, S_RX_OUT:
            begin
               if (SIE_RX_I.byte_valid && idx_q < CW'(BUF_BYTES))
               begin
                  idx_q <= idx_q + CW'(1);
               end
               if (SIE_RX_I.done)
               begin
                  state_q <= S_IDLE;
               end
            end
            S_TX_FETCH: state_q <= S_TX_SEND;
            S_TX_SEND:
            begin
               if (SIE_TX_READY_I)
               begin
                  idx_q <= idx_q + CW'(1);
                  state_q <= (in_cnt_q == '0 || idx_q + CW'(1) >= in_cnt_q) ? S_WAIT_HS
                                                                            : S_TX_FETCH;
               end
            end
            S_WAIT_HS:
            begin
               // a missing handshake leaves toggle, hold and buffer for a retry
               if (SIE_HS_ACK_I || SIE_HS_TIMEOUT_I)
               begin
                  state_q <= S_IDLE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // in data: zero count gives one empty beat
   always_comb
   begin
      SIE_TX_O.valid = state_q == S_TX_SEND;
      SIE_TX_O.data = in_cnt_q == '0 ? 8'h00 : in_rdata;
      SIE_TX_O.empty = in_cnt_q == '0;
      SIE_TX_O.last = in_cnt_q == '0 || idx_q + CW'(1) >= in_cnt_q;
      SIE_TX_O.data1 = in_cfg_q.toggle;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // handshake to host

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         hs_valid_q <= 1'b0;
         hs_code_q <= UEC_HS_ACK;
      end
      else
      begin
         hs_valid_q <= 1'b0;
         if (state_q == S_IDLE && tok_ep0 && SIE_TOK_I.pid == UEC_PID_IN
             && (setup_flag_q || in_cfg_q.stall || in_cfg_q.hold || !in_cfg_q.enable))
         begin
            hs_valid_q <= 1'b1;
            hs_code_q <= setup_flag_q ? UEC_HS_NAK
                       : in_cfg_q.stall ? UEC_HS_STALL : UEC_HS_NAK;
         end
         else if (state_q == S_RX_SETUP && rx_good)
         begin
            hs_valid_q <= 1'b1;
            hs_code_q <= UEC_HS_ACK;
         end
         else if (state_q == S_RX_OUT && rx_good)
         begin
            hs_valid_q <= 1'b1;
            hs_code_q <= setup_bad_q ? UEC_HS_NAK
                       : stall_q ? UEC_HS_STALL
                       : accept_q ? UEC_HS_ACK : UEC_HS_NAK;
         end
      end
   end

   assign HS_VALID_O = hs_valid_q;
   assign HS_CODE_O = hs_code_q;

   ////////////////////////////////////////////////////////////////////////////////
   // endpoint configuration and counts

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         out_cfg_q <= `UEC_CFG_RST;
         in_cfg_q <= `UEC_CFG_RST;
         out_cnt_q <= `UEC_CNT_RST;
         in_cnt_q <= `UEC_CNT_RST;
      end
      else
      begin
         if (wr_out_cfg)
         begin
            out_cfg_q <= PWDATA_I[4:0];
         end
         if (wr_in_cfg)
         begin
            in_cfg_q <= PWDATA_I[4:0];
         end
         if (wr_in_cnt)
         begin
            in_cnt_q <= PWDATA_I[CW-1:0] > CW'(BUF_BYTES) ? CW'(BUF_BYTES) : PWDATA_I[CW-1:0];
         end
         // hardware updates win over a firmware write in the same cycle
         if (out_done)
         begin
            out_cnt_q <= idx_q + CW'(SIE_RX_I.byte_valid && idx_q < CW'(BUF_BYTES));
            out_cfg_q.toggle <= !out_cfg_q.toggle;
            out_cfg_q.hold <= 1'b1;
         end
         if (in_acked)
         begin
            in_cfg_q.toggle <= !in_cfg_q.toggle;
            in_cfg_q.hold <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // setup flag and interrupt requests

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         setup_flag_q <= 1'b0;
         setup_irq_q <= 1'b0;
         out_irq_q <= 1'b0;
         in_irq_q <= 1'b0;
      end
      else
      begin
         // write one to clear; a new event in the same cycle wins
         if (wr_status && PWDATA_I[`UEC_ST_SETUP_IRQ])
         begin
            setup_irq_q <= 1'b0;
            setup_flag_q <= 1'b0;
         end
         if (wr_status && PWDATA_I[`UEC_ST_OUT_IRQ])
         begin
            out_irq_q <= 1'b0;
         end
         if (wr_status && PWDATA_I[`UEC_ST_IN_IRQ])
         begin
            in_irq_q <= 1'b0;
         end
         if (state_q == S_RX_SETUP && rx_good)
         begin
            setup_flag_q <= 1'b1;
            setup_irq_q <= 1'b1;
         end
         if (out_done && out_cfg_q.irq_en)
         begin
            out_irq_q <= 1'b1;
         end
         if (in_acked && in_cfg_q.irq_en)
         begin
            in_irq_q <= 1'b1;
         end
      end
   end

   assign SETUP_IRQ_O = setup_irq_q;
   assign OUT_IRQ_O = out_irq_q;
   assign IN_IRQ_O = in_irq_q;

   ////////////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup phase

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         prdata_q <= '0;
         rd_region_q <= `UEC_REG_REGS;
         err_q <= 1'b0;
      end
      else if (apb_setup)
      begin
         rd_region_q <= region;
         err_q <= unmapped;
         prdata_q <= '0;
         unique case (offset)
            `UEC_OFS_OUT_CFG: prdata_q <= {27'h0, out_cfg_q};
            `UEC_OFS_OUT_CNT: prdata_q <= 32'(out_cnt_q);
            `UEC_OFS_IN_CFG: prdata_q <= {27'h0, in_cfg_q};
            `UEC_OFS_IN_CNT: prdata_q <= 32'(in_cnt_q);
            `UEC_OFS_STATUS: prdata_q <= {28'h0, in_irq_q, out_irq_q, setup_irq_q, setup_flag_q};
            default: prdata_q <= '0;
         endcase
      end
   end

   always_comb
   begin
      unique case (rd_region_q)
         `UEC_REG_OUT_BUF: PRDATA_O = {24'h0, out_rdata};
         `UEC_REG_IN_BUF: PRDATA_O = 32'h0;
         `UEC_REG_SETUP_BUF: PRDATA_O = {24'h0, setup_rdata};
         default: PRDATA_O = prdata_q;
      endcase
      if (err_q)
      begin
         PRDATA_O = 32'h0;
      end
   end

   assign PREADY_O = 1'b1;
   assign PSLVERR_O = PSEL_I && PENABLE_I && err_q;

endmodule

// ===== dv/uec_ep0_chk.sv
// port assertions of the endpoint-zero handler
`timescale 1ns/1ps
module uec_ep0_chk
   import uec_pkg::*;
(
   // clock and reset
   input wire logic CLK_SYS_I,
   input wire logic RESET_N_I,
   // apb
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [3:0] PSTRB_I,
   // usb side
   input wire uec_tok_t SIE_TOK_I,
   input wire uec_rx_t SIE_RX_I,
   input wire logic SIE_HS_TIMEOUT_I,
   input wire uec_tx_t SIE_TX_O,
   input wire logic HS_VALID_O,
   input wire uec_hs_t HS_CODE_O,
   // interrupts
   input wire logic SETUP_IRQ_O,
   input wire logic OUT_IRQ_O,
   input wire logic IN_IRQ_O
);
   default clocking dc @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESET_N_I);
   logic in_tok;
   logic st_wr;
   assign in_tok = SIE_TOK_I.valid && SIE_TOK_I.pid == UEC_PID_IN && SIE_TOK_I.ep == 4'h0;
   assign st_wr = PSEL_I && PENABLE_I && PWRITE_I && PSTRB_I[0] && PADDR_I == 12'h010;
   sequence s_hs(uec_hs_t c);
      HS_VALID_O && HS_CODE_O == c;
   endsequence
   sequence s_tx_start;
      !HS_VALID_O ##1 SIE_TX_O.valid;
   endsequence
   property p_out_ack;
      $rose(OUT_IRQ_O) |-> s_hs(UEC_HS_ACK);
   endproperty
   a_out_ack: assert property (p_out_ack) else $error("out irq without ack");
   property p_err_quiet;
      SIE_RX_I.done && SIE_RX_I.err |=> !HS_VALID_O;
   endproperty
   a_err_quiet: assert property (p_err_quiet) else $error("handshake on bad packet");
   property p_setup_ack;
      $rose(SETUP_IRQ_O) |-> s_hs(UEC_HS_ACK);
   endproperty
   a_setup_ack: assert property (p_setup_ack) else $error("setup irq without ack");
   property p_setup_nak;
      in_tok && SETUP_IRQ_O |=> s_hs(UEC_HS_NAK);
   endproperty
   a_setup_nak: assert property (p_setup_nak) else $error("in not refused in setup");
   property p_in_answer;
      in_tok |=> s_hs(UEC_HS_NAK) or s_hs(UEC_HS_STALL) or s_tx_start;
   endproperty
   a_in_answer: assert property (p_in_answer) else $error("in token unanswered");
   property p_retry;
      SIE_HS_TIMEOUT_I && !IN_IRQ_O |=> !IN_IRQ_O;
   endproperty
   a_retry: assert property (p_retry) else $error("in irq on silent host");
   property p_setup_clr;
      st_wr && PWDATA_I[1] && !SIE_RX_I.done |=> !SETUP_IRQ_O;
   endproperty
   a_setup_clr: assert property (p_setup_clr) else $error("setup irq not cleared");
   property p_sticky;
      $fell(OUT_IRQ_O) || $fell(IN_IRQ_O) |-> $past(st_wr);
   endproperty
   a_sticky: assert property (p_sticky) else $error("irq dropped by itself");
endmodule

// ===== dv/uec_host_model.sv
// usb host and serial engine model for endpoint zero
`timescale 1ns/1ps
module uec_host_model
   import uec_pkg::*;
(
   // clock
   input wire logic clk_i,
   // towards the handler
   output uec_tok_t tok_o,
   output uec_rx_t rx_o,
   output logic hs_ack_o,
   output logic hs_timeout_o,
   output logic tx_ready_o,
   // from the handler
   input wire uec_tx_t tx_i
);
   initial
   begin
      tok_o = '0;
      rx_o = '0;
      hs_ack_o = 1'b0;
      hs_timeout_o = 1'b0;
      tx_ready_o = 1'b0;
   end
   task token(input uec_pid_t pid);
      @(posedge clk_i);
      tok_o <= '{1'b1, pid, 4'h0};
      @(posedge clk_i);
      tok_o.valid <= 1'b0;
   endtask
   // released data line shows the inverse of the last byte
   task packet(input uec_pid_t pid, input logic d1, input int n, input logic err,
      input logic [7:0] b);
      token(pid);
      for (int i = 0; i < n; i++)
      begin
         rx_o <= '{1'b1, b + 8'(i), 1'b0, 1'b0, d1};
         @(posedge clk_i);
      end
      rx_o <= '{1'b0, ~rx_o.data, 1'b1, err, d1};
      @(posedge clk_i);
      rx_o.done <= 1'b0;
   endtask
   // slow host drops ready every other cycle; silent host sends no handshake
   task in_xfer(input logic ack, input logic slow, output int n, output logic [7:0] b0,
      output logic d1, output logic zl);
      int t;
      n = 0;
      t = 0;
      token(UEC_PID_IN);
      tx_ready_o <= !slow;
      while (t < 400)
      begin
         @(posedge clk_i);
         t++;
         if (tx_i.valid && tx_ready_o)
         begin
            if (n == 0) b0 = tx_i.data;
            d1 = tx_i.data1;
            zl = tx_i.empty;
            n++;
            if (tx_i.last) t = 400;
         end
         if (t < 400) tx_ready_o <= !slow || !t[0];
      end
      tx_ready_o <= 1'b0;
      hs_ack_o <= ack;
      hs_timeout_o <= !ack;
      @(posedge clk_i);
      hs_ack_o <= 1'b0;
      hs_timeout_o <= 1'b0;
   endtask
endmodule

// ===== dv/uec_ep0_bench.sv
// self-checking bench of the endpoint-zero handler
`timescale 1ns/1ps
module uec_ep0_bench
   import uec_pkg::*;
;
   typedef struct {logic [4:0] cfg; int n; logic err, d1, hv; uec_hs_t code; int cnt;
      logic irq;} uec_row_t;
   uec_row_t rows [7] = '{'{5'h1a, 3, 0, 1, 1, UEC_HS_ACK, 3, 1},
      '{5'h1c, 2, 0, 0, 1, UEC_HS_NAK, 3, 0}, '{5'h19, 2, 0, 1, 1, UEC_HS_STALL, 3, 0},
      '{5'h18, 4, 1, 0, 0, UEC_HS_ACK, 3, 0}, '{5'h18, 65, 0, 0, 1, UEC_HS_ACK, 64, 1},
      '{5'h1a, 2, 0, 0, 1, UEC_HS_ACK, 64, 0}, '{5'h12, 2, 0, 0, 1, UEC_HS_NAK, 64, 0}};
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr, slv, hs_ack, hs_to, tx_rdy;
   logic hs_valid, setup_irq, out_irq, in_irq, d1, zl;
   logic [7:0] b0;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   uec_tok_t tok;
   uec_rx_t rx;
   uec_tx_t tx;
   uec_hs_t hs_code;
   int errors, checks, n;
   uec_ep0 i_uec_ep0 (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PSTRB_I(4'hf), .PREADY_O(pready), .PRDATA_O(prdata), .PSLVERR_O(pslverr),
      .SIE_TOK_I(tok), .SIE_RX_I(rx), .SIE_HS_ACK_I(hs_ack), .SIE_HS_TIMEOUT_I(hs_to),
      .SIE_TX_O(tx), .SIE_TX_READY_I(tx_rdy), .HS_VALID_O(hs_valid), .HS_CODE_O(hs_code),
      .SETUP_IRQ_O(setup_irq), .OUT_IRQ_O(out_irq), .IN_IRQ_O(in_irq));
   uec_host_model i_uec_host_model (.clk_i(clk), .tok_o(tok), .rx_o(rx), .hs_ack_o(hs_ack),
      .hs_timeout_o(hs_to), .tx_ready_o(tx_rdy), .tx_i(tx));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // count handshake pulses in the answer window
   task hs(input logic v, input uec_hs_t c);
      int k;
      uec_hs_t code;
      k = 0;
      repeat (4)
      begin
         @(posedge clk);
         if (hs_valid === 1'b1) code = hs_code;
         if (hs_valid === 1'b1) k++;
      end
      chk(k, v);
      if (v) chk(code, c);
   endtask
   task print_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      print_verdict();
   end
   ////////////////////////////////////////
   initial
   begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rchk(12'h000, 32'h04);
      rchk(12'h008, 32'h04);
      rchk(12'h400, 32'h0);
      chk(slv, 1'b1);
      apb(1'b1, 12'h000, 32'h1a);
      apb(1'b1, 12'h008, 32'h1a);
      i_uec_host_model.packet(UEC_PID_SETUP, 1'b0, 8, 1'b0, 8'h80);
      hs(1'b1, UEC_HS_ACK);
      chk(setup_irq, 1'b1);
      rchk(12'h010, 32'h3);
      rchk(12'h31c, 32'h87);
      apb(1'b1, 12'h008, 32'h1b);
      apb(1'b1, 12'h000, 32'h1b);
      i_uec_host_model.packet(UEC_PID_OUT, 1'b1, 2, 1'b0, 8'h10);
      hs(1'b1, UEC_HS_NAK);
      i_uec_host_model.token(UEC_PID_IN);
      hs(1'b1, UEC_HS_NAK);
      apb(1'b1, 12'h010, 32'h2);
      rchk(12'h010, 32'h0);
      i_uec_host_model.token(UEC_PID_IN);
      hs(1'b1, UEC_HS_STALL);
      i_uec_host_model.packet(UEC_PID_OUT, 1'b1, 2, 1'b0, 8'h10);
      hs(1'b1, UEC_HS_STALL);
      for (int i = 0; i < 3; i++) apb(1'b1, 12'h200 + 12'(4 * i), 32'h20 + i);
      apb(1'b1, 12'h00c, 32'h3);
      apb(1'b1, 12'h008, 32'h1a);
      i_uec_host_model.in_xfer(1'b1, 1'b1, n, b0, d1, zl);
      chk(n, 3);
      chk(b0, 8'h20);
      chk(d1, 1'b1);
      rchk(12'h008, 32'h1c);
      chk(in_irq, 1'b1);
      i_uec_host_model.token(UEC_PID_IN);
      hs(1'b1, UEC_HS_NAK);
      apb(1'b1, 12'h010, 32'h8);
      apb(1'b1, 12'h00c, 32'h0);
      apb(1'b1, 12'h008, 32'h1a);
      i_uec_host_model.in_xfer(1'b0, 1'b0, n, b0, d1, zl);
      rchk(12'h008, 32'h1a);
      chk(in_irq, 1'b0);
      i_uec_host_model.in_xfer(1'b1, 1'b0, n, b0, d1, zl);
      chk(n, 1);
      chk({zl, d1}, 2'b11);
      rchk(12'h008, 32'h1c);
      chk(in_irq, 1'b1);
      foreach (rows[r])
      begin
         apb(1'b1, 12'h010, 32'he);
         apb(1'b1, 12'h000, 32'(rows[r].cfg));
         i_uec_host_model.packet(UEC_PID_OUT, rows[r].d1, rows[r].n, rows[r].err, 8'h40 + 8'(r));
         hs(rows[r].hv, rows[r].code);
         rchk(12'h004, rows[r].cnt);
         chk(out_irq, rows[r].irq);
         if (rows[r].irq)
         begin
            rchk(12'h100, 32'h40 + r);
            rchk(12'h000, 32'((rows[r].cfg | 5'h04) ^ 5'h02));
         end
      end
      // mid-run reset: count cleared, endpoint back to held
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      rchk(12'h004, 32'h0);
      i_uec_host_model.token(UEC_PID_IN);
      hs(1'b1, UEC_HS_NAK);
      print_verdict();
   end
endmodule
bind uec_ep0 uec_ep0_chk i_uec_ep0_chk (.CLK_SYS_I(CLK_SYS_I), .RESET_N_I(RESET_N_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
   .PWDATA_I(PWDATA_I), .PSTRB_I(PSTRB_I), .SIE_TOK_I(SIE_TOK_I), .SIE_RX_I(SIE_RX_I),
   .SIE_HS_TIMEOUT_I(SIE_HS_TIMEOUT_I), .SIE_TX_O(SIE_TX_O), .HS_VALID_O(HS_VALID_O),
   .HS_CODE_O(HS_CODE_O), .SETUP_IRQ_O(SETUP_IRQ_O), .OUT_IRQ_O(OUT_IRQ_O),
   .IN_IRQ_O(IN_IRQ_O));
